// file: logic/pcms_sequencer.sv
// Power-on reset delay and configuration/user mode sequencer
`timescale 1ns/1ps
`include "pcms_consts.svh"
module pcms_sequencer #(
   parameter logic [`PCMS_CNT_W-1:0] POR_LONG_CYC =
      `PCMS_CNT_W'(`PCMS_POR_LONG_CYC),
   parameter logic [`PCMS_CNT_W-1:0] POR_SHORT_CYC =
      `PCMS_CNT_W'(`PCMS_POR_SHORT_CYC)
)
(
   // Free-running oscillator clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // Supply monitor and straps
   input  wire logic               supply_ok,
   input  wire logic               por_delay_select,
   input  wire logic               pullup_off_strap,
   // Configuration controller side
   input  wire logic               reconfig_n,
   output logic                    config_req,
   input  wire logic               config_done,
   // Core control
   output pcms_pkg::pcms_ctl_t     ctl
);
   pcms_pkg::pcms_state_t        state;
   pcms_pkg::pcms_state_t        next_state;
   logic [`PCMS_CNT_W-1:0]       cnt;
   logic                         strap_long;
   logic                         in_config;

   // Selected power-on count; shared by the sequencer and its checker
   function automatic logic [`PCMS_CNT_W-1:0] por_target(
      input logic long_sel
   );
      return long_sel ? POR_LONG_CYC : POR_SHORT_CYC;
   endfunction

   // Strap caught by a clocked process; async reset may not sample ports
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || state == pcms_pkg::PCMS_POR && !supply_ok)
         strap_long <= ~por_delay_select;
   end

   always_comb
   begin
      next_state = state;
      case (state)
         pcms_pkg::PCMS_POR:
            if (supply_ok && cnt == por_target(strap_long))
               next_state = pcms_pkg::PCMS_WAIT_CFG;
         pcms_pkg::PCMS_WAIT_CFG:
            next_state = pcms_pkg::PCMS_CONFIG;
         pcms_pkg::PCMS_CONFIG:
            if (config_done)
               next_state = pcms_pkg::PCMS_INIT;
         pcms_pkg::PCMS_INIT:
            if (cnt == `PCMS_CNT_W'(`PCMS_INIT_CYC))
               next_state = pcms_pkg::PCMS_USER;
         pcms_pkg::PCMS_USER:
            if (!reconfig_n)
               next_state = pcms_pkg::PCMS_WAIT_CFG;
         default:
            next_state = pcms_pkg::PCMS_POR;
      endcase
      // Supply loss drops back to reset from anywhere
      if (!supply_ok)
         next_state = pcms_pkg::PCMS_POR;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         state <= pcms_pkg::PCMS_POR;
      else
         state <= next_state;
   end

   // Delay counter restarts on every state change and while supplies bad
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || next_state != state || !supply_ok)
         cnt <= '0;
      else if (cnt != '1)
         cnt <= cnt + `PCMS_CNT_W'(1);
   end

   assign in_config = state == pcms_pkg::PCMS_CONFIG;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctl        <= '{io_oe: 1'b0, pullup_en: 1'b0,
                         core_rst: 1'b1, user_mode: 1'b0};
      end
      else
      begin
         ctl.io_oe     <= next_state == pcms_pkg::PCMS_USER;
         ctl.core_rst  <= next_state != pcms_pkg::PCMS_USER;
         ctl.user_mode <= next_state == pcms_pkg::PCMS_USER;
         ctl.pullup_en <= !pullup_off_strap
                          && next_state != pcms_pkg::PCMS_USER
                          && next_state != pcms_pkg::PCMS_POR;
      end
   end

   // Load request is a level for the whole configuration phase
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         config_req <= 1'b0;
      else
         config_req <= next_state == pcms_pkg::PCMS_CONFIG;
   end

   chk_oe_needs_user: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctl.io_oe |-> state == pcms_pkg::PCMS_USER)
      else $error("I/O enabled outside user mode");
   chk_no_drive_supply: assert property (@(posedge core_clk)
      disable iff (!rst_n) !supply_ok |=> !ctl.io_oe)
      else $error("Outputs driven without supplies");
   chk_por_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == pcms_pkg::PCMS_POR && !supply_ok |=>
         state == pcms_pkg::PCMS_POR)
      else $error("Left reset with bad supplies");
   chk_por_count: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(state == pcms_pkg::PCMS_WAIT_CFG) && $past(state) ==
         pcms_pkg::PCMS_POR |-> $past(cnt) ==
         por_target(strap_long))
      else $error("Reset released before delay elapsed");
   chk_cfg_to_init: assert property (@(posedge core_clk) disable iff (!rst_n)
      in_config && config_done && supply_ok |=>
         state == pcms_pkg::PCMS_INIT ##5 state == pcms_pkg::PCMS_USER)
      else $error("Initialization sequence wrong");
   chk_mode_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctl.user_mode == (state == pcms_pkg::PCMS_USER))
      else $error("Mode flag out of step");
   chk_reconfig: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == pcms_pkg::PCMS_USER && !reconfig_n && supply_ok |=>
         !ctl.user_mode ##1 config_req)
      else $error("Reconfiguration not entered");
   chk_pullup_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      pullup_off_strap |=> !ctl.pullup_en)
      else $error("Pull-ups on while strap high");
   chk_cfg_before_user: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(ctl.user_mode) |->
         $past(state, 6) == pcms_pkg::PCMS_CONFIG)
      else $error("User mode without configuration");

   chk_cnt_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
      !supply_ok |=> cnt == '0)
      else $error("Delay count kept while supplies bad");

   chk_wait_one: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == pcms_pkg::PCMS_WAIT_CFG && supply_ok |=>
         state == pcms_pkg::PCMS_CONFIG)
      else $error("Load not started after wait");

   chk_user_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == pcms_pkg::PCMS_USER && reconfig_n && supply_ok |=>
         state == pcms_pkg::PCMS_USER)
      else $error("User mode left without request");

   chk_strap_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      state != pcms_pkg::PCMS_POR |=> $stable(strap_long))
      else $error("Delay strap changed after power-up");

   chk_rst_user: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctl.core_rst == (state != pcms_pkg::PCMS_USER))
      else $error("Core reset out of step with mode");

   chk_req_config: assert property (@(posedge core_clk) disable iff (!rst_n)
      config_req == (state == pcms_pkg::PCMS_CONFIG))
      else $error("Load request out of step");

   chk_pullup_por: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == pcms_pkg::PCMS_POR |-> !ctl.pullup_en)
      else $error("Pull-ups on during power-on reset");

   chk_por_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == pcms_pkg::PCMS_POR |-> ctl.core_rst && !ctl.io_oe)
      else $error("Core active during power-on reset");

   chk_user_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(state == pcms_pkg::PCMS_USER) |->
         $past(state) == pcms_pkg::PCMS_INIT)
      else $error("User mode entered without init");

   chk_cfg_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(state == pcms_pkg::PCMS_CONFIG) |->
         $past(state) == pcms_pkg::PCMS_WAIT_CFG)
      else $error("Load entered out of order");

   chk_oe_rst: assert property (@(posedge core_clk) disable iff (!rst_n)
      ctl.core_rst |-> !ctl.io_oe)
      else $error("Outputs driven while core in reset");
endmodule

// file: include/pcms_consts.svh
// Timing and field constants for the power-on and mode sequencer
`ifndef PCMS_CONSTS_SVH
`define PCMS_CONSTS_SVH
`define PCMS_CLK_MHZ        125
`define PCMS_POR_LONG_MS    100
`define PCMS_POR_SHORT_MS   12
`define PCMS_CYC_PER_MS     (`PCMS_CLK_MHZ * 1000)
`define PCMS_POR_LONG_CYC   (`PCMS_POR_LONG_MS * `PCMS_CYC_PER_MS)
`define PCMS_POR_SHORT_CYC  (`PCMS_POR_SHORT_MS * `PCMS_CYC_PER_MS)
`define PCMS_CNT_W          24
`define PCMS_INIT_CYC       4
`endif

// file: include/pcms_pkg.sv
// Types for the power-on and mode sequencer
package pcms_pkg;
   typedef enum logic [2:0] {
      PCMS_POR,
      PCMS_WAIT_CFG,
      PCMS_CONFIG,
      PCMS_INIT,
      PCMS_USER
   } pcms_state_t;

   typedef struct packed {
      logic io_oe;
      logic pullup_en;
      logic core_rst;
      logic user_mode;
   } pcms_ctl_t;
endpackage

// file: verification/pcms_ctrl_model.sv
// Configuration controller model that answers load requests
`timescale 1ns/1ps
module pcms_ctrl_model (
   // Clock and load request
   input  wire logic       core_clk,
   input  wire logic       config_req,
   input  wire logic [3:0] lat,
   // Load complete
   output logic            config_done
);
   logic [3:0] cnt;
   // Data is sent anew on every request, slow or prompt by lat
   always_ff @(posedge core_clk)
   begin
      cnt         <= config_req ? cnt + 4'h1 : 4'h0;
      config_done <= config_req && cnt == lat;
   end
endmodule

// file: verification/pcms_sequencer_test.sv
// Self-checking bench for the power-on and mode sequencer
`timescale 1ns/1ps
module pcms_sequencer_test;
   logic                core_clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                ok = 1'b0;
   logic                sel = 1'b0;
   logic                pu = 1'b0;
   logic                rc_n = 1'b1;
   logic                req;
   logic                done;
   logic [3:0]          lat = 4'h0;
   pcms_pkg::pcms_ctl_t ctl;
   int                  failures = 0;
   int                  n_checks = 0;
   logic [7:0]          n;
   always #4 core_clk = ~core_clk;
   pcms_sequencer #(.POR_LONG_CYC(24'h28), .POR_SHORT_CYC(24'ha)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .supply_ok(ok),
      .por_delay_select(sel), .pullup_off_strap(pu), .reconfig_n(rc_n),
      .config_req(req), .config_done(done), .ctl(ctl));
   pcms_ctrl_model model (.core_clk(core_clk), .config_req(req),
      .lat(lat), .config_done(done));
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic step(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // Counts edges until the watched output reaches v
   task automatic wt(bit usr, logic v);
      n = 8'h0;
      while ((usr ? ctl.user_mode : req) !== v)
      begin
         step(1);
         n++;
         if (n == 8'hc8)
         begin
            failures++;
            stop_test();
         end
      end
   endtask
   initial
   begin
      void'($urandom(78));
      for (int t = 0; t < 6; t++)
      begin
         rst_n = 1'b0;
         ok = 1'b0;
         sel = t < 2 ? t[0] : 1'($urandom);
         pu = 1'($urandom);
         lat = 4'($urandom % 8);
         step(20);
         rst_n = 1'b1;
         step(1);
         chk("ctl_por", 8'h2, {4'h0, ctl});
         ok = 1'b1;
         wt(1'b0, 1'b1);
         chk("delay", sel ? 8'hc : 8'h2a, n);
         chk("ctl_cfg", {5'h0, ~pu, 2'h2}, {4'h0, ctl});
         wt(1'b0, 1'b0);
         wt(1'b1, 1'b1);
         chk("init_len", 8'h5, n);
         chk("ctl_user", 8'h9, {4'h0, ctl});
         rc_n = 1'b0;
         step(1);
         rc_n = 1'b1;
         chk("ctl_recfg", {5'h0, ~pu, 2'h2}, {4'h0, ctl});
         wt(1'b0, 1'b1);
         chk("recfg_req", 8'h1, n);
         wt(1'b1, 1'b1);
         ok = 1'b0;
         step(2);
         chk("ctl_down", 8'h2, {3'h0, req, ctl});
         $display("test %0d done", t);
      end
      stop_test();
   end
endmodule
